// ==== ssp_slave.sv ====
// Overview of operation
// - control bits 6:0 hold register address
// - control bit 7 zero means write
// - select high ends write transaction
// - control bit 7 one means read
// - read data on output or shared line
// - read address increments after every byte
// - select high ends read, releases line
// - mode 11: idle high, sample rising
// - only one data byte per write
// - THREE_WIRE_I input high selects 3-wire
module ssp_slave
  import ssp_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  input  wire logic        CSB_N_I,
  input  wire logic        SCK_I,
  input  wire logic        SDI_I,
  input  wire logic        THREE_WIRE_I,
  input  wire logic [7:0]  REG_RDATA_I,
  output logic             SDI_O,
  output logic             SDI_OE_O,
  output logic             SERIAL_OUT_LINE_O,
  output logic             SERIAL_OUT_LINE_OE_O,
  output ssp_req_t         REQ_O
);

  ssp_pins_t  pins;
  ssp_state_t state_r;
  ssp_state_t state_nxt;
  logic [2:0] bit_r;
  logic [7:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic [6:0] addr_r;
  logic       drive_r;
  logic       sck_rise;
  logic       sck_fall;
  logic       csb_rise;
  logic       csb_fall;
  logic       byte_done;
  logic [7:0] in_byte;
  logic       is_read;

  assign pins = '{csb_n: CSB_N_I, sck: SCK_I, sdi: SDI_I};

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on serial clock and select
  // both pins idle high, so the previous level resets high; a pin that is low
  // at reset release reads as a fall, never as a spurious rise

  ssp_edge u_sck (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RESET_I),
    .lvl_i     (pins.sck),
    .rst_val_i (1'h1),
    .rise_o    (sck_rise),
    .fall_o    (sck_fall)
  );

  ssp_edge u_csb (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RESET_I),
    .lvl_i     (pins.csb_n),
    .rst_val_i (1'h1),
    .rise_o    (csb_rise),
    .fall_o    (csb_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of the incoming byte

  // the pins are already in the system clock domain, so a rising sck is seen
  // one system clock after the host drives it, with the data bit still steady
  // sample on rising
  // sck samples only count while select is low; idle-high clock gives no edge
  wire sample = sck_rise & ~pins.csb_n;
  wire shift  = sck_fall & ~pins.csb_n;
  assign in_byte   = {sh_in_r[6:0], pins.sdi};
  assign byte_done = sample & (bit_r == BIT_LAST);
  assign is_read   = (in_byte[CTRL_RW_BIT] == RW_READ);

  // phase sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSP_IDLE: begin
        if (csb_fall) begin
          state_nxt = SSP_CTRL;
        end
      end
      SSP_CTRL: begin
        if (byte_done) begin
          state_nxt = is_read ? SSP_RDATA : SSP_WDATA;
        end
      end
      SSP_WDATA: begin
        if (byte_done) begin
          state_nxt = SSP_IDLE;
        end
      end
      SSP_RDATA: begin
        state_nxt = SSP_RDATA;
      end
    endcase
    if (pins.csb_n) begin
      state_nxt = SSP_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, bit counter and input shifter

  // a byte cut short by select high leaves no count behind, so the next
  // frame always starts its control byte at bit 7
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_r <= SSP_IDLE;
      bit_r   <= BIT_FIRST;
      sh_in_r <= BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
      if (pins.csb_n | csb_fall) begin
        bit_r <= BIT_FIRST;     // realigns framing even after a short byte
      end else if (sample) begin
        bit_r   <= bit_r + 3'h1;
        sh_in_r <= in_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register address and access strobes

  wire ctrl_done = (state_r == SSP_CTRL) & byte_done;
  wire wr_done   = (state_r == SSP_WDATA) & byte_done;
  wire rd_next   = (state_r == SSP_RDATA) & byte_done;

  // a read fetches the next register at the end of every byte, a byte ahead of
  // the host; the fetch after the last byte is never shifted out, so a register
  // file with read side effects sees one extra read per frame
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      addr_r <= ADDR_ZERO;
      REQ_O  <= '0;
    end else begin
      REQ_O.wr_stb <= wr_done;
      REQ_O.rd_stb <= (ctrl_done & is_read) | rd_next;
      if (ctrl_done) begin
        addr_r     <= in_byte[ADDR_W-1:0];
        REQ_O.addr <= in_byte[ADDR_W-1:0];
      end else if (rd_next) begin
        addr_r     <= addr_r + ADDR_STEP;
        REQ_O.addr <= addr_r + ADDR_STEP;
      end
      if (wr_done) begin
        REQ_O.wdata <= in_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shifter; register data arrives the cycle after rd_stb
  //
  // mode 11 puts every output bit up on a falling sck and the host takes it on
  // the next rising one. the shifter is loaded between bytes, and each fall of
  // the data phase moves its msb into the pin flop out_r: the first fall of a
  // byte shows bit 7 and the eighth shows bit 0. shifting the loaded byte on
  // that first fall instead would lose bit 7 and send every byte one bit early.

  logic load_pend_r;
  logic out_r;

  // one data-phase fall: present the next bit and advance the shifter
  wire  out_step = shift & (state_r == SSP_RDATA);

  // msb first out
  // the load waits one cycle for the register file; a fall cannot land in that
  // cycle while the host keeps sck high for three system clocks or more
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      sh_out_r    <= BYTE_ZERO;
      load_pend_r <= 1'h0;
      out_r       <= 1'h0;
      drive_r     <= 1'h0;
    end else begin
      load_pend_r <= REQ_O.rd_stb;
      if (load_pend_r) begin
        sh_out_r <= REQ_O.rd_stb ? sh_out_r : REG_RDATA_I;
      end else if (out_step) begin
        sh_out_r <= {sh_out_r[6:0], 1'h0};
      end
      if (out_step) begin
        out_r <= sh_out_r[BYTE_W-1];
      end
      drive_r <= (state_nxt == SSP_RDATA);
    end
  end

  // the pin flop moves only on a data-phase fall, so the level that the host
  // samples on the rising sck has stood since one system clock after the fall
  wire out_bit = out_r;
  wire use_shared = THREE_WIRE_I;

  // pin selection
  // both pins carry the same flop; only the enables differ between wirings
  assign SDI_O                = out_bit;
  assign SDI_OE_O             = drive_r & use_shared;
  assign SERIAL_OUT_LINE_O    = out_bit;
  assign SERIAL_OUT_LINE_OE_O = drive_r & ~use_shared;

endmodule

// ==== ssp_pkg.sv ====
package ssp_pkg;

  // control byte layout
  localparam int unsigned CTRL_RW_BIT   = 7;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned BIT_CNT_W     = 3;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  localparam logic        RW_WRITE      = 1'h0;
  localparam logic        RW_READ       = 1'h1;
  localparam logic [6:0]  ADDR_STEP     = 7'h01;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [6:0]  ADDR_ZERO     = 7'h00;

  // transaction phases
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_CTRL,
    SSP_WDATA,
    SSP_RDATA
  } ssp_state_t;

  // register access request towards the register file
  typedef struct packed {
    logic       wr_stb;
    logic       rd_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ssp_req_t;

  // serial pins sampled in the system clock domain
  typedef struct packed {
    logic csb_n;
    logic sck;
    logic sdi;
  } ssp_pins_t;

endpackage

// ==== ssp_edge.sv ====
// edge detector on a synchronous level input
module ssp_edge
  import ssp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lvl_i,
  input  wire logic rst_val_i,
  output wire logic rise_o,
  output wire logic fall_o
);

  logic prev_r;

  // previous level, held at the idle value in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= rst_val_i;
    end else begin
      prev_r <= lvl_i;
    end
  end

  assign rise_o = lvl_i & ~prev_r;
  assign fall_o = ~lvl_i & prev_r;

endmodule

// ==== ssp_slave_asserts.sv ====
module ssp_slave_asserts
  import ssp_pkg::*;
(
  input  wire logic     CLK_SYS_I,
  input  wire logic     RESET_I,
  input  wire logic     CSB_N_I,
  input  wire logic     SCK_I,
  input  wire logic     THREE_WIRE_I,
  input  wire logic     SERIAL_OUT_LINE_O,
  input  wire logic     SDI_OE_O,
  input  wire logic     SERIAL_OUT_LINE_OE_O,
  input  wire ssp_req_t REQ_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  logic [6:0] la_r;
  logic       lv_r;
  logic       wv_r;
  wire        oe = SDI_OE_O | SERIAL_OUT_LINE_OE_O;
  // frame history: cleared while select is high
  always_ff @(posedge CLK_SYS_I) begin
    lv_r <= !RESET_I && !CSB_N_I && (lv_r || REQ_O.rd_stb);
    wv_r <= !RESET_I && !CSB_N_I && (wv_r || REQ_O.wr_stb);
    if (REQ_O.rd_stb) begin
      la_r <= REQ_O.addr;
    end
  end
  sequence s_oe_up;
    ##[1:2] oe;
  endsequence
  a_oe_start: assert property (REQ_O.rd_stb |-> s_oe_up) else $error("no drive after read");
  a_oe_cause: assert property ($rose(oe) |-> REQ_O.rd_stb) else $error("drive without read");
  a_three_sel: assert property (SDI_OE_O |-> THREE_WIRE_I) else $error("shared line in 4-wire");
  a_four_sel: assert property (SERIAL_OUT_LINE_OE_O |-> !THREE_WIRE_I) else $error("out line in 3-wire");
  a_oe_release: assert property (CSB_N_I [*3] |-> !oe) else $error("drive after deselect");
  a_idle_quiet: assert property (CSB_N_I [*3] |-> !REQ_O.wr_stb && !REQ_O.rd_stb) else $error("strobe idle");
  a_one_write: assert property (REQ_O.wr_stb |-> !wv_r) else $error("second write in frame");
  a_rd_step: assert property (REQ_O.rd_stb && lv_r |-> REQ_O.addr == la_r + ADDR_STEP) else $error("bad step");
  a_one_strobe: assert property (!(REQ_O.wr_stb && REQ_O.rd_stb)) else $error("both strobes");
  a_out_hold: assert property (SCK_I && $past(SCK_I) |-> $stable(SERIAL_OUT_LINE_O)) else $error("data moved");
endmodule
bind ssp_slave ssp_slave_asserts i_chk (
  .CLK_SYS_I(CLK_SYS_I),
  .RESET_I(RESET_I),
  .CSB_N_I(CSB_N_I),
  .SCK_I(SCK_I),
  .THREE_WIRE_I(THREE_WIRE_I),
  .SERIAL_OUT_LINE_O(SERIAL_OUT_LINE_O),
  .SDI_OE_O(SDI_OE_O),
  .SERIAL_OUT_LINE_OE_O(SERIAL_OUT_LINE_OE_O),
  .REQ_O(REQ_O)
);

// ==== ssp_host_model.sv ====
module ssp_host_model
  import ssp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic din_i,
  output logic      csb_n_o,
  output logic      sck_o,
  output logic      dout_o,
  output logic      oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, clock parked high
  initial begin
    csb_n_o = 1'b1;
    sck_o = 1'b1;
    dout_o = 1'b1;
    oe_o = 1'b0;
  end
  task automatic sel(input logic lvl);
    @(posedge clk_i);
    csb_n_o <= lvl;
    oe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // drive after fall, sample at rise, msb first
  // the data line is let go one clock after the last rise, once the slave has
  // taken that bit, so a 3-wire read never has both sides driving
  task automatic xfer(input logic [7:0] tx, input logic drv, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge clk_i);
      sck_o <= 1'b0;
      oe_o <= drv;
      dout_o <= tx[i];
      repeat (4) @(posedge clk_i);
      rx[i] = din_i;
      sck_o <= 1'b1;
      @(posedge clk_i);
      if (i == 8 - nb) oe_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
endmodule

// ==== tb.sv ====
module tb;
  import ssp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, tw = 1'b0, h_csb, h_sck, h_dout, h_oe, sdi_o, sdi_oe, so, so_oe;
  logic [7:0] rdata = 8'h00, rx, rf [128], ref_m [128];
  ssp_req_t req;
  logic [6:0] w_a;
  logic [7:0] w_d;
  int fail_count = 0, check_count = 0, cyc = 0, seed = 38387, wr_seen = 0;
  // pull-up holds the released line high
  wire line = sdi_oe ? sdi_o : (h_oe ? h_dout : 1'b1);
  wire din = tw ? line : (so_oe ? so : 1'b1);
  always #25 clk = ~clk;
  ssp_slave i_dut (.CLK_SYS_I(clk), .RESET_I(rst), .CSB_N_I(h_csb), .SCK_I(h_sck), .SDI_I(line),
    .THREE_WIRE_I(tw), .REG_RDATA_I(rdata), .SDI_O(sdi_o), .SDI_OE_O(sdi_oe), .SERIAL_OUT_LINE_O(so),
    .SERIAL_OUT_LINE_OE_O(so_oe), .REQ_O(req));
  ssp_host_model i_host (.clk_i(clk), .din_i(din), .csb_n_o(h_csb), .sck_o(h_sck), .dout_o(h_dout), .oe_o(h_oe));
  // register file behind the slave, plus the hang guard
  always @(posedge clk) begin
    if (req.rd_stb) rdata <= rf[req.addr];
    if (req.wr_stb) rf[req.addr] <= req.wdata;
    if (req.wr_stb) begin
      wr_seen <= wr_seen + 1;
      chk({1'b0, req.addr}, {1'b0, w_a});
      chk(req.wdata, w_d);
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // nb 8 plain, under 8 aborted, 16 with an ignored extra byte
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb);
    int n0;
    n0 = wr_seen;
    w_a = a;
    w_d = d;
    i_host.sel(1'b0);
    i_host.xfer({RW_WRITE, a}, 1'b1, 8, rx);
    i_host.xfer(d, 1'b1, nb > 8 ? 8 : nb, rx);
    if (nb > 8) i_host.xfer(~d, 1'b1, 8, rx);
    i_host.sel(1'b1);
    chk(8'(wr_seen - n0), nb >= 8 ? 8'h01 : 8'h00);
    if (nb >= 8) ref_m[a] = d;
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    i_host.sel(1'b0);
    i_host.xfer({RW_READ, a}, 1'b1, 8, rx);
    for (int k = 0; k < n; k++) begin
      i_host.xfer(8'h00, 1'b0, 8, rx);
      chk(rx, ref_m[7'(a + k)]);
      chk(8'({sdi_oe, so_oe}), tw ? 8'h02 : 8'h01);
    end
    i_host.sel(1'b1);
    chk(8'({sdi_oe, so_oe}), 8'h00);
  endtask
  // writes, read back through both wirings
  initial begin
    logic [6:0] a;
    for (int i = 0; i < 128; i++) begin
      rf[i] = 8'($random(seed));
      ref_m[i] = rf[i];
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      tw <= m[0];
      for (int j = 0; j < 6; j++) begin
        a = 7'($random(seed));
        wr(a, 8'($random(seed)), j == 4 ? 4 : (j == 5 ? 16 : 8));
        rd(a - 7'h01, 3);
      end
      rd(7'h7E, 4);
    end
    summarize();
  end
endmodule
